// File: hdl/uimc_irq_mask_port.sv
// Interrupt mask set/clear ports with master gate and interrupt request.
// Assumes a synchronous word-wide register port driven by the bus slave.
//
// Notes on behaviour
// RULE_01: Writing one to a defined bit of the clear port clears that mask bit.
// RULE_02: Writing zero to a bit of the clear port leaves that mask bit unchanged.
// RULE_03: Reading the clear port returns the live mask contents.
// RULE_04: A one at bit 31 clears the master gate and a zero there is ignored.
// RULE_05: Hardware or software reset leaves the master gate and mask cleared.
// RULE_06: Each per-event bit gates only its own event source at its fixed position.
// RULE_07: The clear port is a 32-bit register at offset 14H of the operational base.
// RULE_08: Reserved bits 29 to 7 ignore writes and read as zero.
// RULE_09: Interrupt requested only when an event flag, its mask bit and the gate are set.
// RULE_10: The set port sets mask bits on ones and ignores zeros.
`timescale 1ns/100ps
module uimc_irq_mask_port (
	input wire logic I_CLK_SYS,
	input wire logic I_RST_N,
	input wire logic I_CE,
	input wire logic I_SOFT_RST,
	input wire logic I_REG_WR,
	input wire logic I_REG_RD,
	input wire logic [7:0] I_REG_ADDR,
	input wire logic [uimc_pkg::DATA_W-1:0] I_REG_WDATA,
	input wire logic [uimc_pkg::DATA_W-1:0] I_EVENT_FLAGS,
	output logic [uimc_pkg::DATA_W-1:0] O_REG_RDATA,
	output logic O_REG_HIT,
	output logic [uimc_pkg::DATA_W-1:0] O_MASK,
	output logic O_IRQ
);
	import uimc_pkg::*;

	uimc_mask_if mif ();
	uimc_acc_t acc;
	logic [31:0] rdata;
	logic [31:0] next_rdata;
	logic irq;
	logic next_irq;
	logic [EVT_N-1:0] evt_hit;

	// ****************************************************************
	// Write decode
	// ****************************************************************
	// Same offset decode serves both reads and writes
	assign acc = uimc_decode(I_REG_ADDR); // RULE_07
	assign mif.set_we = I_REG_WR && (acc == ACC_SET); // RULE_10
	assign mif.clr_we = I_REG_WR && (acc == ACC_CLEAR); // RULE_01
	assign mif.wdata = I_REG_WDATA;
	assign mif.soft_rst = I_SOFT_RST; // RULE_05
	assign O_REG_HIT = (acc != ACC_NONE);

	uimc_mask_store u_store (
		.i_clk(I_CLK_SYS),
		.i_rst_n(I_RST_N),
		.i_ce(I_CE),
		.m(mif)
	);

	// ****************************************************************
	// Event gating
	// ****************************************************************
	// One AND per event so each bit gates only its own source
	genvar g;
	generate
		for (g = 0; g < EVT_N; g++) begin : g_evt
			assign evt_hit[g] = I_EVENT_FLAGS[EVT_POS[g]] && mif.mask[EVT_POS[g]]; // RULE_06
		end
	endgenerate

	// Read data and request, computed from the live mask
	always_comb begin
		next_rdata = 32'h00000000;
		if (I_REG_RD && (acc != ACC_NONE)) begin
			next_rdata = mif.mask & MASK_DEFINED; // RULE_03 RULE_08
		end
		next_irq = mif.mask[BIT_MASTER_GATE] && (|evt_hit); // RULE_09
	end

	// Registered outputs; unmapped reads answer zero
	always_ff @(posedge I_CLK_SYS or negedge I_RST_N) begin
		if (!I_RST_N) begin
			rdata <= 32'h00000000;
			irq <= 1'b0;
		end else if (I_CE) begin
			rdata <= next_rdata;
			irq <= next_irq;
		end
	end

	assign O_REG_RDATA = rdata;
	assign O_IRQ = irq;
	assign O_MASK = mif.mask;

	// ****************************************************************
	// Checks
	// ****************************************************************
	AST_READ_MIRROR: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		(I_CE && I_REG_RD && acc == ACC_CLEAR && !I_REG_WR && !I_SOFT_RST)
		|=> (O_REG_RDATA == O_MASK)) else $error("read not mask"); // RULE_03
	AST_ZERO_KEEPS: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		(I_CE && mif.clr_we && !I_SOFT_RST)
		|=> ((O_MASK & ~$past(I_REG_WDATA)) == ($past(O_MASK) & ~$past(I_REG_WDATA))))
		else $error("zero write changed mask"); // RULE_02
	AST_GATE_CLR: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		(I_CE && mif.clr_we && I_REG_WDATA[BIT_MASTER_GATE]) |=> !O_MASK[BIT_MASTER_GATE])
		else $error("gate not cleared"); // RULE_04
	AST_SOFT_RST: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		(I_CE && I_SOFT_RST) |=> (O_MASK == 32'h00000000) ##1 !O_IRQ)
		else $error("soft reset left mask"); // RULE_05
	AST_SET_PORT: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		(I_CE && mif.set_we && !mif.clr_we && !I_SOFT_RST)
		|=> ((O_MASK & $past(I_REG_WDATA) & MASK_DEFINED) == ($past(I_REG_WDATA) & MASK_DEFINED)))
		else $error("set port failed"); // RULE_10
	AST_IRQ_CAUSE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		$past(I_CE) && O_IRQ |-> $past(O_MASK[BIT_MASTER_GATE])
		&& ($past(I_EVENT_FLAGS & O_MASK & MASK_EVENTS) != 32'h00000000))
		else $error("irq without cause"); // RULE_09 RULE_06
	AST_UNMAPPED: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		(I_CE && acc == ACC_NONE) |=> (O_REG_RDATA == 32'h00000000))
		else $error("unmapped read nonzero"); // RULE_07
	AST_RSVD_READ: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N)
		(O_REG_RDATA & ~MASK_DEFINED) == 32'h00000000) else $error("reserved read nonzero"); // RULE_08

	// ****************************************************************
	// Request, hold and decode checks
	// ****************************************************************
	// A live cause with the gate open must raise the request next cycle
	AST_IRQ_WHEN_CAUSE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // RULE_09
		(I_CE && O_MASK[BIT_MASTER_GATE]
		&& ((I_EVENT_FLAGS & O_MASK & MASK_EVENTS) != 32'h00000000)) |=> O_IRQ)
		else $error("cause without irq");

	// Closed gate silences every source
	AST_NO_GATE_NO_IRQ: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // RULE_09
		(I_CE && !O_MASK[BIT_MASTER_GATE]) |=> !O_IRQ)
		else $error("irq with gate closed");

	// Frozen enable keeps the mask; a dropped write must not leak through
	AST_CE_FREEZE_MASK: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // RULE_02
		!I_CE |=> $stable(O_MASK))
		else $error("mask moved while frozen");

	// Frozen enable keeps the request
	AST_CE_FREEZE_IRQ: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // RULE_09
		!I_CE |=> $stable(O_IRQ))
		else $error("irq moved while frozen");

	// Frozen enable keeps the read data
	AST_CE_FREEZE_RDATA: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // RULE_03
		!I_CE |=> $stable(O_REG_RDATA))
		else $error("read data moved while frozen");

	// Hit flag follows the two mapped offsets only
	AST_HIT_DECODE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // RULE_07
		O_REG_HIT == ((I_REG_ADDR == OFS_MASK_SET) || (I_REG_ADDR == OFS_MASK_CLEAR)))
		else $error("hit decode wrong");

	// Writes to unmapped offsets are dropped
	AST_UNMAPPED_WRITE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // RULE_07
		(I_CE && I_REG_WR && (acc == ACC_NONE) && !I_SOFT_RST) |=> $stable(O_MASK))
		else $error("unmapped write changed mask");

	// Without a write or reset the mask holds
	AST_NO_WRITE_HOLD: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // RULE_02
		(I_CE && !I_REG_WR && !I_SOFT_RST) |=> $stable(O_MASK))
		else $error("mask changed without write");

	// A zero at the gate position of the clear port leaves the gate alone
	AST_GATE_ZERO_KEEPS: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // RULE_04
		(I_CE && mif.clr_we && !I_REG_WDATA[BIT_MASTER_GATE] && !I_SOFT_RST)
		|=> (O_MASK[BIT_MASTER_GATE] == $past(O_MASK[BIT_MASTER_GATE])))
		else $error("gate changed on zero");

	// The set port reads back the same live mask
	AST_SET_READ_MIRROR: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // RULE_03
		(I_CE && I_REG_RD && (acc == ACC_SET) && !I_REG_WR && !I_SOFT_RST)
		|=> (O_REG_RDATA == O_MASK))
		else $error("set port read not mask");

	// Read data clears on the next enabled cycle without a read, so stale words linger only while the enable is frozen
	AST_RDATA_IDLE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // RULE_03
		(I_CE && !I_REG_RD) |=> (O_REG_RDATA == 32'h00000000))
		else $error("read data without read");

	// Software reset in an enabled cycle shuts the gate whatever writes happen that cycle
	AST_SOFT_GATE: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // RULE_05
		(I_CE && I_SOFT_RST) |=> !O_MASK[BIT_MASTER_GATE])
		else $error("gate open after soft reset");

	// ****************************************************************
	// Per-event checks
	// ****************************************************************
	// One pair per source: its own mask bit, with the gate, decides its request
	generate
		for (g = 0; g < EVT_N; g++) begin : g_evt_chk
			AST_EVT_MASKED: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // RULE_06
				(I_CE && (I_EVENT_FLAGS == (32'h00000001 << EVT_POS[g]))
				&& !O_MASK[EVT_POS[g]]) |=> !O_IRQ)
				else $error("masked source raised irq");
			AST_EVT_FIRES: assert property (@(posedge I_CLK_SYS) disable iff (!I_RST_N) // RULE_06
				(I_CE && O_MASK[BIT_MASTER_GATE] && I_EVENT_FLAGS[EVT_POS[g]]
				&& O_MASK[EVT_POS[g]]) |=> O_IRQ)
				else $error("enabled source gave no irq");
		end
	endgenerate
endmodule : uimc_irq_mask_port

// File: include/uimc_pkg.sv
// Package for the interrupt mask set/clear port block.
// Assumes a single 40 MHz controller clock and word-wide register access.
package uimc_pkg;
	// ****************************************************************
	// Register map and field layout
	// ****************************************************************
	localparam logic [7:0] OFS_MASK_SET = 8'h10;
	localparam logic [7:0] OFS_MASK_CLEAR = 8'h14;
	localparam logic [7:0] OFS_EVENT_FLAGS = 8'h0C;
	localparam logic [7:0] OFS_BASE_CFG = 8'h10;
	localparam int DATA_W = 32;
	localparam int BIT_MASTER_GATE = 31;
	localparam int BIT_OWNERSHIP = 30;
	localparam int BIT_ROOT_HUB = 6;
	localparam int BIT_FRAME_OVF = 5;
	localparam int BIT_UNRECOV = 4;
	localparam int BIT_RESUME = 3;
	localparam int BIT_SOF = 2;
	localparam int BIT_DONE_WB = 1;
	localparam int BIT_SCHED_OVR = 0;
	localparam logic [31:0] MASK_DEFINED = 32'hC000007F;
	localparam logic [31:0] MASK_EVENTS = 32'h4000007F;
	localparam logic [31:0] MASK_RESET = 32'h00000000;
	localparam int EVT_N = 8;
	// Event positions in register bit order, index 0..7
	localparam int EVT_POS [EVT_N] = '{BIT_SCHED_OVR, BIT_DONE_WB, BIT_SOF, BIT_RESUME,
		BIT_UNRECOV, BIT_FRAME_OVF, BIT_ROOT_HUB, BIT_OWNERSHIP};

	// Register access kind decoded from an offset
	typedef enum {ACC_NONE, ACC_SET, ACC_CLEAR} uimc_acc_t;

	// Decode an offset into the kind of mask access
	function automatic uimc_acc_t uimc_decode(input logic [7:0] ofs);
		uimc_acc_t kind;
		kind = ACC_NONE;
		if (ofs == OFS_MASK_SET) begin
			kind = ACC_SET;
		end else if (ofs == OFS_MASK_CLEAR) begin
			kind = ACC_CLEAR;
		end
		return kind;
	endfunction : uimc_decode
endpackage : uimc_pkg

// File: include/uimc_mask_if.sv
// Interface carrying mask update requests and mask state between modules.
// Assumes both ends run on the controller clock.
`timescale 1ns/100ps
interface uimc_mask_if;
	logic set_we;
	logic clr_we;
	logic [31:0] wdata;
	logic soft_rst;
	logic [31:0] mask;
	// Requester drives writes, store returns mask
	modport req (output set_we, output clr_we, output wdata, output soft_rst, input mask);
	modport store (input set_we, input clr_we, input wdata, input soft_rst, output mask);
endinterface : uimc_mask_if

// File: hdl/uimc_mask_store.sv
// Holds the interrupt enable mask updated by set and clear ports.
// Assumes requests are one-cycle strobes qualified by the clock enable.
`timescale 1ns/100ps
module uimc_mask_store (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	uimc_mask_if.store m
);
	import uimc_pkg::*;

	logic [31:0] mask;
	logic [31:0] next_mask;

	// ****************************************************************
	// Mask update
	// ****************************************************************
	// Clear wins over set if both hit the same cycle: the safe outcome
	always_comb begin
		next_mask = mask;
		if (m.soft_rst) begin
			next_mask = MASK_RESET; // RULE_05
		end else begin
			if (m.set_we) begin
				next_mask = next_mask | (m.wdata & MASK_DEFINED); // RULE_10
			end
			if (m.clr_we) begin
				next_mask = next_mask & ~(m.wdata & MASK_DEFINED); // RULE_01 RULE_02 RULE_04
			end
		end
	end

	// Register stage
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			mask <= MASK_RESET; // RULE_05
		end else if (i_ce) begin
			mask <= next_mask;
		end
	end

	assign m.mask = mask;

	// Reserved bits never become set
	AST_RSVD_ZERO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(mask & ~MASK_DEFINED) == 32'h00000000) else $error("reserved mask bit set"); // RULE_08
	// Clear write takes effect next cycle
	AST_CLR_EFFECT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		(i_ce && m.clr_we) |=> ((mask & $past(m.wdata) & MASK_DEFINED) == 32'h00000000))
		else $error("clear did not clear"); // RULE_01
endmodule : uimc_mask_store

// File: sim/uimc_event_src.sv
// Partner model: event source that raises the controller's event flags.
// Assumes the bench pulses i_new just after a rising clock edge.
`timescale 1ns/100ps
module uimc_event_src (
	input wire logic i_clk,
	input wire logic i_new,
	input wire logic [31:0] i_only,
	output logic [31:0] o_flags = 32'h00000000
);
	// New flag word per request; a nonzero i_only is driven as the whole flag word
	always @(posedge i_clk) begin
		if (i_new) begin
			o_flags <= (i_only != 32'h00000000) ? i_only : $urandom;
		end
	end
endmodule : uimc_event_src

// File: sim/usb_hc_irq_mask_clear_port_bench.sv
// Self-checking bench for the interrupt mask set and clear ports.
// Assumes the event source partner model is compiled alongside.
`timescale 1ns/100ps
module usb_hc_irq_mask_clear_port_bench;
	import uimc_pkg::*;
	logic clk = 0, rst_n = 0, ce = 1, srst = 0, wr = 0, rd = 0, ev_new = 0, hit, irq;
	logic [7:0] addr = 8'h00;
	logic [31:0] wdata = 32'h00000000, only = 32'h00000000, flags, rdata, mask, exp;
	int failures = 0, checks_done = 0, cycles = 0;
	uimc_irq_mask_port dut_u (.I_CLK_SYS(clk), .I_RST_N(rst_n), .I_CE(ce), .I_SOFT_RST(srst),
		.I_REG_WR(wr), .I_REG_RD(rd), .I_REG_ADDR(addr), .I_REG_WDATA(wdata),
		.I_EVENT_FLAGS(flags), .O_REG_RDATA(rdata), .O_REG_HIT(hit), .O_MASK(mask), .O_IRQ(irq));
	uimc_event_src ev_u (.i_clk(clk), .i_new(ev_new), .i_only(only), .o_flags(flags));
	// 40 MHz clock
	initial begin
		forever #12.5 clk = ~clk;
	end
	// Reference mask update; clear wins nothing here since writes never overlap
	function automatic logic [31:0] upd(logic [31:0] m, logic [7:0] a, logic [31:0] d);
		if (a == 8'h10) return m | (d & 32'hC000007F);
		if (a == 8'h14) return m & ~d;
		return m;
	endfunction : upd
	function automatic logic [31:0] irq_of(logic [31:0] m, logic [31:0] f);
		return {31'h0, m[31] & (|(m & f & 32'h4000007F))};
	endfunction : irq_of
	// Mostly mapped offsets, sometimes any byte
	function automatic logic [7:0] pick();
		case ($urandom % 3)
			0: return 8'h10;
			1: return 8'h14;
			default: return 8'($urandom);
		endcase
	endfunction : pick
	task automatic step();
		@(posedge clk);
		#1;
	endtask : step
	task automatic check(logic [31:0] got, logic [31:0] want);
		checks_done++;
		if (got !== want) begin
			failures++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask : check
	task automatic wr_word(logic [7:0] a, logic [31:0] d);
		wr = 1;
		addr = a;
		wdata = d;
		step();
		wr = 0;
		exp = upd(exp, a, d);
	endtask : wr_word
	task automatic rd_word(logic [7:0] a);
		rd = 1;
		addr = a;
		#1;
		check({31'h0, hit}, {31'h0, a == 8'h10 || a == 8'h14});
		step();
		rd = 0;
		check(rdata, (a == 8'h10 || a == 8'h14) ? exp : 32'h0);
	endtask : rd_word
	// Fresh flags, then the registered request one cycle later
	task automatic probe();
		ev_new = 1;
		step();
		ev_new = 0;
		step();
		check({31'h0, irq}, irq_of(exp, flags));
	endtask : probe
	task automatic tally_and_finish();
		if (failures == 0 && checks_done > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : tally_and_finish
	// Hang guard, far above the few hundred cycles the run needs
	always @(posedge clk) begin
		cycles++;
		if (cycles == 5000) begin
			failures++;
			tally_and_finish();
		end
	end
	initial begin
		exp = 32'h0;
		void'($urandom(88007));
		repeat (8) @(posedge clk);
		#1 rst_n = 1;
		check(mask, 32'h0);
		rd_word(8'h14);
		wr_word(8'h10, 32'hFFFFFFFF);
		check(mask, 32'hC000007F);
		wr_word(8'h14, 32'h00000000);
		check(mask, exp);
		only = 32'h4000007F;
		probe();
		wr_word(8'h14, 32'h80000000);
		probe();
		// Each enable bit guards only its own source
		for (int i = 0; i < EVT_N; i++) begin
			wr_word(8'h10, 32'hFFFFFFFF);
			only = 32'h1 << EVT_POS[i];
			probe();
			wr_word(8'h14, only);
			probe();
		end
		only = 32'h0;
		repeat (60) begin
			wr_word(pick(), $urandom);
			check(mask, exp);
			rd_word(pick());
			probe();
		end
		// Frozen clock enable drops the write
		ce = 0;
		wr = 1;
		addr = 8'h14;
		wdata = 32'hFFFFFFFF;
		step();
		wr = 0;
		ce = 1;
		check(mask, exp);
		wr_word(8'h10, 32'hFFFFFFFF);
		srst = 1;
		step();
		srst = 0;
		exp = 32'h0;
		check(mask, 32'h0);
		probe();
		tally_and_finish();
	end
endmodule : usb_hc_irq_mask_clear_port_bench
